// ==== common/scw_pkg.sv ====
// safety control word decoder: shared constants, types and register map
// assumes a 32-bit apb with byte addresses, one register per aligned word
package scw_pkg;
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 8;
    localparam int          WORD_W        = 16;
    localparam int          NUM_RAMP      = 4;
    localparam int          NUM_EVT       = 4;
    // register byte offsets
    localparam logic [7:0]  OFS_FB_SEL    = 8'h00;
    localparam logic [7:0]  OFS_WORD      = 8'h04;
    localparam logic [7:0]  OFS_STATE     = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_CLR   = 8'h10;
    localparam logic [7:0]  OFS_IRQ_EN    = 8'h14;
    // selection values
    localparam logic [7:0]  FB_SEL_NONE   = 8'h00;
    localparam logic [7:0]  FB_SEL_RST    = 8'h00;
    localparam logic [15:0] WORD_RST      = 16'h0000;
    // ramp function indices
    localparam int          IDX_SS1       = 0;
    localparam int          IDX_SS2       = 1;
    localparam int          IDX_SOS       = 2;
    localparam int          IDX_SLS       = 3;
    // interrupt event bit positions
    localparam int          EVT_ACK       = 0;
    localparam int          EVT_DROP      = 1;
    localparam int          EVT_SENSOR    = 2;
    localparam int          EVT_CHANGE    = 3;
    // safety_control_word layout, msb first; select bits are active low
    typedef struct packed {
        logic [4:0] dev_specific;
        logic       speed_level_high_bit;
        logic       speed_level_low_bit;
        logic       reserved_8;
        logic       fault_ack;
        logic [1:0] reserved_5_6;
        logic       sls_deselect;
        logic       sos_deselect;
        logic       ss2_deselect;
        logic       ss1_deselect;
        logic       sto_deselect;
    } ctrl_word_t;
    // drive-side commands
    typedef struct packed {
        logic coast_stop;
        logic quick_stop;
        logic stop_monitor_start;
        logic fault_ack_pulse;
    } drive_cmd_t;
    typedef enum logic [1:0] {
        FN_IDLE,
        FN_DECEL,
        FN_ACTIVE
    } fn_state_t;
endpackage : scw_pkg

// ==== rtl/safety_control_word_decoder.sv ====
// safety control word decoder: telegram word to safety function control
// assumes telegram_valid and the drive status inputs come from logic on pclk
//
// Behaviour
// - select of bit 0 low activates torque off and commands coast stop.
// - bit 1 low: quick stop, start monitor timer, torque off after decel.
// - bit 1 high ends stop-1 at once unless a fault holds it.
// - bit 2 low: quick stop, monitor timer, operating stop; needs safe sensors.
// - bit 2 high ends stop-2 at once unless a fault holds it.
// - bit 3 low starts ramp supervision, operating stop after decel.
// - bit 3 high ends operating stop unless fault or stop-2 standstill.
// - bit 4 low: ramp supervision, limited speed after decel; safe sensors.
// - bit 4 high ends limited speed unless a fault holds it.
// - falling edge of bit 7 acknowledges faults; steady level does nothing.
// - bits 10 and 9 give speed level 0 to 3; bit 4 requests it.
// - bits 5, 6 and 8 are reserved and unused.
// - word accepted only when fieldbus selection names this protocol.
`timescale 1ns/1ps
`default_nettype none
module safety_control_word_decoder
    import scw_pkg::*;
#(
    parameter logic [7:0] PROTO_CODE = 8'h01
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [DATA_W-1:0]   pwdata,
    output logic      [DATA_W-1:0]   prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                telegram_valid,
    input  wire logic [WORD_W-1:0]   telegram_word,
    input  wire logic [NUM_RAMP:0]   fault_demand,
    input  wire logic                decel_done,
    input  wire logic                safe_sensors_ok,
    output logic                     safe_torque_off,
    output logic [NUM_RAMP-1:0]      ramp_fn_active,
    output logic [1:0]               speed_level,
    output drive_cmd_t               drive_cmd,
    output logic                     irq
);

    ctrl_word_t                word_reg;
    logic                      ack_prev_reg;
    logic [7:0]                fb_sel_reg;
    logic [NUM_EVT-1:0]        irq_stat_reg;
    logic [NUM_EVT-1:0]        irq_en_reg;
    logic                      sensor_trip_reg;
    fn_state_t                 st_reg  [NUM_RAMP];
    fn_state_t                 st_next [NUM_RAMP];
    logic [NUM_RAMP-1:0]       sel;
    logic [NUM_RAMP-1:0]       hold;
    logic [NUM_RAMP-1:0]       sensor_bad;
    logic [NUM_EVT-1:0]        evt;
    logic                      accept;
    logic                      ack_edge;
    logic                      wr_en;
    logic                      setup;

    // select bits of the four ramp functions, active low in the word
    function automatic logic [NUM_RAMP-1:0] ramp_select(input ctrl_word_t w);
        ramp_select = ~{w.sls_deselect, w.sos_deselect, w.ss2_deselect, w.ss1_deselect};
    endfunction : ramp_select

    function automatic logic needs_sensor(input int idx);
        needs_sensor = (idx != IDX_SS1);
    endfunction : needs_sensor

    // one decode for the error response, so a new register cannot be half mapped
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = a inside {OFS_FB_SEL, OFS_WORD, OFS_STATE,
                                OFS_IRQ_STAT, OFS_IRQ_CLR, OFS_IRQ_EN};
    endfunction : addr_mapped

    // word capture
    assign accept = telegram_valid && (fb_sel_reg == PROTO_CODE)
                    && (fb_sel_reg != FB_SEL_NONE);

    // bits 5, 6, 8 and 11..15 are kept for readback only, nothing decodes them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_reg <= WORD_RST;
        end else if (accept) begin
            word_reg <= telegram_word;
        end
    end

    // reset word selects every function, so the drive starts torque-free
    assign sel = ramp_select(word_reg);

    // acknowledge edge, evaluated only between accepted telegrams
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_prev_reg <= 1'b0;
        end else if (accept) begin
            ack_prev_reg <= telegram_word[7];
        end
    end

    assign ack_edge = accept && ack_prev_reg && !telegram_word[7];

    // other-function sub state constraints
    always_comb begin
        hold          = fault_demand[NUM_RAMP:1];
        hold[IDX_SOS] = fault_demand[IDX_SOS+1]
                        || (st_reg[IDX_SS2] == FN_ACTIVE);
    end

    // ramp function state machines
    generate
        for (genvar i = 0; i < NUM_RAMP; i++) begin : g_ramp
            assign sensor_bad[i] = sel[i] && needs_sensor(i) && !safe_sensors_ok;
            always_comb begin
                st_next[i] = st_reg[i];
                case (st_reg[i])
                    FN_IDLE: begin
                        if ((sel[i] && !sensor_bad[i]) || hold[i]) begin
                            st_next[i] = FN_DECEL;
                        end
                    end
                    FN_DECEL: begin
                        if (!sel[i] && !hold[i]) begin
                            st_next[i] = FN_IDLE;
                        end else if (decel_done) begin
                            st_next[i] = FN_ACTIVE;
                        end
                    end
                    FN_ACTIVE: begin
                        if (!sel[i] && !hold[i]) begin
                            st_next[i] = FN_IDLE;
                        end
                    end
                    default: begin
                        st_next[i] = FN_IDLE;
                    end
                endcase
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    st_reg[i] <= FN_IDLE;
                end else begin
                    st_reg[i] <= st_next[i];
                end
            end
        end
    endgenerate

    // one process owns the whole output vector, so no bit has two writers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_fn_active <= '0;
        end else begin
            for (int j = 0; j < NUM_RAMP; j++) begin
                ramp_fn_active[j] <= (st_next[j] == FN_ACTIVE);
            end
        end
    end

    // missing safe sensors cannot be supervised, so fall back to torque off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sensor_trip_reg <= 1'b0;
        end else begin
            sensor_trip_reg <= |sensor_bad;
        end
    end

    // torque off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            safe_torque_off <= 1'b1;
        end else begin
            safe_torque_off <= !word_reg.sto_deselect
                               || fault_demand[0]
                               || sensor_trip_reg
                               || (st_next[IDX_SS1] == FN_ACTIVE);
        end
    end

    // drive commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_cmd <= '0;
        end else begin
            drive_cmd.coast_stop         <= !word_reg.sto_deselect;
            drive_cmd.quick_stop         <= (st_next[IDX_SS1] == FN_DECEL)
                                            || (st_next[IDX_SS2] == FN_DECEL);
            drive_cmd.stop_monitor_start <= ((st_reg[IDX_SS1] == FN_IDLE)
                                             && (st_next[IDX_SS1] == FN_DECEL))
                                            || ((st_reg[IDX_SS2] == FN_IDLE)
                                             && (st_next[IDX_SS2] == FN_DECEL));
            drive_cmd.fault_ack_pulse    <= ack_edge;
        end
    end

    // speed level; the request itself is the limited-speed select bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_level <= 2'b00;
        end else begin
            speed_level <= {word_reg.speed_level_high_bit,
                            word_reg.speed_level_low_bit};
        end
    end

    // events
    always_comb begin
        evt             = '0;
        evt[EVT_ACK]    = ack_edge;
        evt[EVT_DROP]   = telegram_valid && !accept;
        evt[EVT_SENSOR] = (|sensor_bad) && !sensor_trip_reg;
        evt[EVT_CHANGE] = accept && (telegram_word != word_reg);
    end

    // apb slave, answers with one access cycle
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !addr_mapped(paddr);
            prdata  <= '0;
            if (setup && !pwrite) begin
                case (paddr)
                    OFS_FB_SEL:   prdata <= {24'h000000, fb_sel_reg};
                    OFS_WORD:     prdata <= {16'h0000, word_reg};
                    OFS_STATE:    prdata <= {24'h000000, speed_level, 1'b0,
                                             ramp_fn_active, safe_torque_off};
                    OFS_IRQ_STAT: prdata <= {28'h0000000, irq_stat_reg};
                    OFS_IRQ_EN:   prdata <= {28'h0000000, irq_en_reg};
                    default:      prdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_sel_reg <= FB_SEL_RST;
            irq_en_reg <= '0;
        end else if (wr_en) begin
            if (paddr == OFS_FB_SEL) begin
                fb_sel_reg <= pwdata[7:0];
            end
            if (paddr == OFS_IRQ_EN) begin
                irq_en_reg <= pwdata[NUM_EVT-1:0];
            end
        end
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
        end else if (wr_en && (paddr == OFS_IRQ_CLR)) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[NUM_EVT-1:0]) | evt;
        end else begin
            irq_stat_reg <= irq_stat_reg | evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_en_reg);
        end
    end

endmodule : safety_control_word_decoder
`default_nettype wire

// ==== testbench/scw_assertions.sv ====
// checker: port-level properties of the safety control word decoder
// assumes a well-formed apb master; bound into every decoder instance
`timescale 1ns/1ps
`default_nettype none
module scw_assertions
    import scw_pkg::*;
#(
    parameter logic [7:0] PROTO_CODE = 8'h01
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              telegram_valid,
    input wire logic [WORD_W-1:0] telegram_word,
    input wire logic              safe_torque_off,
    input wire logic [3:0]        ramp_fn_active,
    input wire logic [1:0]        speed_level,
    input wire drive_cmd_t        drive_cmd
);
    logic [7:0] fb_sel_reg;
    logic       ack_prev_reg;
    logic       acc;
    // shadow of the selection register, so acceptance is known here
    assign acc = telegram_valid && fb_sel_reg == PROTO_CODE && fb_sel_reg != 8'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) fb_sel_reg <= 8'h00;
        else if (psel && penable && pready && pwrite && paddr == OFS_FB_SEL) fb_sel_reg <= pwdata[7:0];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ack_prev_reg <= 1'b0;
        else if (acc) ack_prev_reg <= telegram_word[7];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    // a second telegram right behind would overwrite the word, so look only at lone ones
    sequence lone_accept_s; acc ##1 !acc; endsequence
    sequence ack_fall_s; acc && ack_prev_reg && !telegram_word[7]; endsequence
    ready_after_setup_a: assert property (setup_s |=> pready) else $error("no ready");
    ready_single_a: assert property (pready |=> !pready) else $error("ready too long");
    slverr_ready_a: assert property (pslverr |-> pready) else $error("stray slverr");
    rdata_idle_a: assert property (!pready |-> prdata == '0) else $error("stray rdata");
    speed_level_a:
        assert property (lone_accept_s |=> speed_level == $past(telegram_word[10:9], 2))
        else $error("bad speed level");
    coast_cmd_a:
        assert property (lone_accept_s |=> drive_cmd.coast_stop == !$past(telegram_word[0], 2))
        else $error("bad coast stop");
    ack_edge_a:
        assert property (ack_fall_s |-> ##[1:2] drive_cmd.fault_ack_pulse) else $error("no ack");
    ack_single_a:
        assert property (drive_cmd.fault_ack_pulse |=> !drive_cmd.fault_ack_pulse)
        else $error("ack too long");
    coast_torque_a:
        assert property (drive_cmd.coast_stop |-> safe_torque_off) else $error("coast w/o sto");
    stop1_torque_a:
        assert property (ramp_fn_active[0] |-> safe_torque_off) else $error("ss1 w/o sto");
    monitor_quick_a:
        assert property (drive_cmd.stop_monitor_start |-> drive_cmd.quick_stop)
        else $error("monitor w/o quick stop");
endmodule : scw_assertions
bind safety_control_word_decoder scw_assertions #(.PROTO_CODE(PROTO_CODE)) i_scw_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .telegram_valid(telegram_valid), .telegram_word(telegram_word),
    .safe_torque_off(safe_torque_off), .ramp_fn_active(ramp_fn_active),
    .speed_level(speed_level), .drive_cmd(drive_cmd)
);
`default_nettype wire

// ==== testbench/scw_controller_model.sv ====
// model of the safety controller that sends cyclic telegrams
// assumes send is called right after a rising edge of pclk
`timescale 1ns/1ps
`default_nettype none
module scw_controller_model
    import scw_pkg::*;
(
    input  wire logic              pclk,
    output logic                   telegram_valid,
    output logic [WORD_W-1:0]      telegram_word
);
    initial begin
        telegram_valid = 1'b0;
        telegram_word  = 16'hffff;
    end
    // between telegrams the word lines carry the inverted word, not the last value
    task automatic send(input logic [WORD_W-1:0] w);
        telegram_valid <= 1'b1;
        telegram_word  <= w;
        @(posedge pclk);
        telegram_valid <= 1'b0;
        telegram_word  <= ~w;
        @(posedge pclk);
    endtask : send
endmodule : scw_controller_model
`default_nettype wire

// ==== testbench/safety_control_word_decoder_tb.sv ====
// testbench: apb and telegram stimulus with self-checks for the decoder
// assumes the package, decoder, checker and controller model are compiled first
`timescale 1ns/1ps
`default_nettype none
module safety_control_word_decoder_tb
    import scw_pkg::*;
;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic                telegram_valid, decel_done, safe_sensors_ok, safe_torque_off;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata, prdata, q;
    logic [WORD_W-1:0]   telegram_word, w;
    logic [NUM_RAMP:0]   fault_demand, f;
    logic [NUM_RAMP-1:0] ramp_fn_active, m;
    logic [1:0]          speed_level;
    drive_cmd_t          drive_cmd;
    int                  errors, comparisons, acks, mons, k;
    integer              seed;
    always #50 pclk = ~pclk;
    always @(posedge pclk) acks <= acks + int'(drive_cmd.fault_ack_pulse);
    always @(posedge pclk) mons <= mons + int'(drive_cmd.stop_monitor_start);
    safety_control_word_decoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .telegram_valid(telegram_valid),
        .telegram_word(telegram_word), .fault_demand(fault_demand), .decel_done(decel_done),
        .safe_sensors_ok(safe_sensors_ok), .safe_torque_off(safe_torque_off),
        .ramp_fn_active(ramp_fn_active), .speed_level(speed_level), .drive_cmd(drive_cmd),
        .irq(irq));
    scw_controller_model i_ctl (.pclk(pclk), .telegram_valid(telegram_valid),
        .telegram_word(telegram_word));
    task automatic summarize;
        if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // bounded access phase, so a slave that never answers ends the run
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            errors++;
            summarize();
        end
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("prdata", q, x);
    endtask : rd
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fault_demand = 5'h00;
        decel_done = 1'b1;
        safe_sensors_ok = 1'b1;
        errors = 0;
        comparisons = 0;
        acks = 0;
        mons = 0;
        seed = 32'hf1644884;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk("sto", safe_torque_off, 1'b1);
        rd(OFS_FB_SEL, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk("pslverr", e, 1'b1);
        i_ctl.send(16'hffff);
        rd(OFS_WORD, 32'h0);
        rd(OFS_IRQ_STAT, 32'h1 << EVT_DROP);
        apb(1'b1, OFS_IRQ_EN, 32'h1 << EVT_DROP);
        repeat (3) @(posedge pclk);
        chk("irq", irq, 1'b1);
        apb(1'b1, OFS_IRQ_EN, 32'h0);
        repeat (3) @(posedge pclk);
        chk("irq", irq, 1'b0);
        apb(1'b1, OFS_IRQ_CLR, 32'hf);
        rd(OFS_IRQ_STAT, 32'h0);
        apb(1'b1, OFS_FB_SEL, {24'($random(seed)), 8'h01});
        rd(OFS_FB_SEL, 32'h1);
        for (int i = 0; i < 24; i++) begin
            w = (i == 0) ? 16'h0600 : 16'($random(seed));
            i_ctl.send(w);
            repeat (8) @(posedge pclk);
            m = w[2] ? 4'hf : 4'hb;
            chk("speed_level", speed_level, w[10:9]);
            chk("coast", drive_cmd.coast_stop, !w[0]);
            chk("sto", safe_torque_off, !(w[0] && w[1]));
            chk("ramp", ramp_fn_active & m, ~w[4:1] & m);
            rd(OFS_WORD, w);
        end
        i_ctl.send(16'hffff);
        decel_done <= 1'b0;
        repeat (8) @(posedge pclk);
        k = mons;
        i_ctl.send(16'hfffd);
        repeat (4) @(posedge pclk);
        chk("monitor", mons - k, 1);
        chk("quick_stop", drive_cmd.quick_stop, 1'b1);
        chk("sto", safe_torque_off, 1'b0);
        decel_done <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("ss1", ramp_fn_active[0], 1'b1);
        chk("sto", safe_torque_off, 1'b1);
        safe_sensors_ok <= 1'b0;
        k = mons;
        i_ctl.send(16'hfffb);
        repeat (6) @(posedge pclk);
        chk("monitor", mons - k, 0);
        chk("ss2", ramp_fn_active[1], 1'b0);
        chk("sto", safe_torque_off, 1'b1);
        safe_sensors_ok <= 1'b1;
        i_ctl.send(16'hffff);
        k = acks;
        i_ctl.send(16'hff7f);
        repeat (4) @(posedge pclk);
        chk("ack", acks - k, 1);
        i_ctl.send(16'hff7f);
        repeat (4) @(posedge pclk);
        chk("ack", acks - k, 1);
        // random fault demands with every function deselected; ss2 standstill holds sos
        for (int i = 0; i < 8; i++) begin
            f = 5'($random(seed));
            fault_demand <= f;
            repeat (8) @(posedge pclk);
            m = f[4:1] | {1'b0, f[2], 2'b00};
            chk("ramp", ramp_fn_active, m);
            chk("sto", safe_torque_off, f[0] || f[1]);
            rd(OFS_STATE, {24'h000000, 2'b11, 1'b0, m, f[0] || f[1]});
        end
        fault_demand <= 5'h01;
        repeat (4) @(posedge pclk);
        chk("sto", safe_torque_off, 1'b1);
        fault_demand <= 5'h00;
        repeat (4) @(posedge pclk);
        chk("sto", safe_torque_off, 1'b0);
        summarize();
    end
endmodule : safety_control_word_decoder_tb
`default_nettype wire
